//--- emb_pkg.sv
`default_nettype none

package emb_pkg;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_BP_ADDR    = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
	localparam logic [7:0] REG_BUS_STATE  = 8'h10;

	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_PULSE_BIT = 1;
	localparam int CTRL_BREAK_BIT = 2;
	localparam int IRQ_BREAK_BIT  = 0;
	localparam int IRQ_DONE_BIT   = 1;
	localparam int IRQ_WIDTH      = 2;

	// ****************************************************************
	// Address ranges
	// ****************************************************************
	localparam logic [15:0] EXT_CODE_BASE = 16'h4000;
	localparam logic [15:0] INT_DATA_TOP  = 16'h3fff;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_PS   = 5000;
	localparam int EXT_ACCESS_NS     = 20;
	localparam int EXT_ACCESS_CYCLES =
		(EXT_ACCESS_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int BP_PULSE_CYCLES   = 8;
	localparam int CNT_WIDTH         = 4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_DONE} emb_phase_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} emb_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} emb_wb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic        code;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} emb_core_req_t;

	typedef struct packed {
		logic       done;
		logic [7:0] rdata;
	} emb_core_rsp_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data_out;
		logic        data_oe;
		logic        strobe_n;
		logic        bkpt;
	} emb_mem_out_t;

	typedef struct packed {
		emb_phase_t           phase;
		logic [CNT_WIDTH-1:0] wait_cnt;
		logic [CNT_WIDTH-1:0] pulse_cnt;
		logic                 sel_meta;
		logic                 code_sel;
		logic [7:0]           din_meta;
		logic [7:0]           din;
		logic                 wr;
		logic                 code;
		logic                 susp;
		logic [15:0]          addr;
		logic [7:0]           dout;
		logic                 oe;
		logic                 strobe_n;
		logic                 bkpt;
		logic [7:0]           rdata;
		logic                 bp_en;
		logic                 bp_pulse;
		logic                 brk;
		logic [15:0]          bp_addr;
		logic [IRQ_WIDTH-1:0] status;
		logic [IRQ_WIDTH-1:0] mask;
		logic                 irq;
		logic                 ack;
		logic [31:0]          rdat;
	} emb_state_t;

endpackage

`default_nettype wire

//--- emb_bus.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] Data bus floats when no external cycle.
// [R2] Read cycles sample bus, write cycles drive.
// [R3] Only external accesses drive the data bus.
// [R4] Suspend drives every data line low.
// [R5] Strobe only for external code fetches.
// [R6] Select low: strobe for 0x4000 to 0xffff.
// [R7] Select high: strobe across whole range.
// [R8] Breakpoint high on enabled address match.
// [R9] Pulse mode: high exactly eight cycles.
// [R10] Latched mode: held until status written one; here held until one is written to the CTRL break bit.
// [R11] Address bus always driven, shows internal address.
// [R12] Reset: address low, float, strobe high.
module emb_bus #(
	parameter int ACCESS_CYCLES = emb_pkg::EXT_ACCESS_CYCLES,
	parameter int PULSE_CYCLES  = emb_pkg::BP_PULSE_CYCLES
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire emb_pkg::emb_wb_req_t   wb_req,
	output var  emb_pkg::emb_wb_rsp_t   wb_rsp,
	input  wire emb_pkg::emb_core_req_t core_req,
	output var  emb_pkg::emb_core_rsp_t core_rsp,
	input  wire logic                   suspend,
	input  wire logic                   external_code_select,
	input  wire logic [7:0]             data_line_in,
	output var  emb_pkg::emb_mem_out_t  mem,
	output logic                        irq
);

	// ****************************************************************
	// Parameter checks
	// ****************************************************************

	// The wait counter is four bits, and reads need the synchroniser lag.
	if (ACCESS_CYCLES < 3 || ACCESS_CYCLES > 15)
	begin : g_bad_access
		$error("ACCESS_CYCLES must lie between 3 and 15.");
	end
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15)
	begin : g_bad_pulse
		$error("PULSE_CYCLES must lie between 1 and 15.");
	end

	localparam logic [3:0] ACCESS_LOAD = 4'(ACCESS_CYCLES - 1);
	localparam logic [3:0] PULSE_LOAD  = 4'(PULSE_CYCLES);

	// Reset leaves the strobe inactive and everything else low.
	localparam emb_pkg::emb_state_t RESET_STATE = '{
		phase:    emb_pkg::PH_IDLE,
		strobe_n: 1'b1,
		default:  '0
	}; // [R12]

	// ****************************************************************
	// State
	// ****************************************************************
	emb_pkg::emb_state_t s;
	emb_pkg::emb_state_t next_s;
	logic                bp_hit;
	logic                ext_access;
	logic                wb_req_on;
	logic                wb_write;
	logic                clear_brk;
	logic [31:0]         read_word;

	// Decides whether a request goes out to the external memory.
	function automatic logic is_external(
		input logic        code,
		input logic [15:0] addr,
		input logic        code_sel
	);
		if (code)
		begin
			is_external = code_sel || (addr >= emb_pkg::EXT_CODE_BASE); // [R6] [R7]
		end
		else
		begin
			is_external = addr > emb_pkg::INT_DATA_TOP;
		end
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Computes the whole next state of the block in one place.
	always_comb
	begin
		next_s = s;
		// The select and data pin inputs pass two flip-flops before use.
		next_s.sel_meta = external_code_select;
		next_s.code_sel = s.sel_meta;
		next_s.din_meta = data_line_in;
		next_s.din      = s.din_meta;
		next_s.susp     = suspend;
		ext_access = is_external(core_req.code, core_req.addr, s.code_sel);
		bp_hit = (s.phase == emb_pkg::PH_IDLE) && core_req.valid &&
			s.bp_en && (core_req.addr == s.bp_addr); // [R8]

		// The register bus answers one cycle after a request.
		wb_req_on   = wb_req.cyc && wb_req.stb;
		next_s.ack  = wb_req_on && !s.ack;
		wb_write    = wb_req_on && s.ack && wb_req.we;
		clear_brk   = 1'b0;

		// Access sequencer towards the external memory.
		case (s.phase)
			emb_pkg::PH_IDLE:
			begin
				// The pins show the core address even for internal work.
				next_s.addr = core_req.addr; // [R11]
				if (core_req.valid)
				begin
					next_s.wr   = core_req.write;
					next_s.code = core_req.code;
					if (ext_access)
					begin
						next_s.phase    = emb_pkg::PH_ACCESS;
						next_s.wait_cnt = ACCESS_LOAD;
						next_s.oe       = core_req.write; // [R2]
						next_s.dout     = core_req.wdata;
						next_s.strobe_n = !core_req.code; // [R5]
					end
					else
					begin
						// Internal work leaves the data pins alone.
						next_s.phase = emb_pkg::PH_DONE; // [R3]
						next_s.rdata = 8'h00;
					end
				end
			end
			emb_pkg::PH_ACCESS:
			begin
				if (s.wait_cnt == 4'h0)
				begin
					next_s.phase    = emb_pkg::PH_DONE;
					next_s.oe       = 1'b0; // [R1]
					next_s.strobe_n = 1'b1;
					next_s.rdata    = s.wr ? 8'h00 : s.din; // [R2]
				end
				else
				begin
					next_s.wait_cnt = s.wait_cnt - 4'h1;
				end
			end
			emb_pkg::PH_DONE:
			begin
				next_s.phase = emb_pkg::PH_IDLE;
			end
			default:
			begin
				next_s.phase    = emb_pkg::PH_IDLE;
				next_s.oe       = 1'b0;
				next_s.strobe_n = 1'b1;
			end
		endcase

		// Register writes take effect on the edge that sees ack.
		if (wb_write)
		begin
			case (wb_req.adr)
				emb_pkg::REG_CTRL:
				begin
					if (wb_req.sel[0])
					begin
						next_s.bp_en    = wb_req.dat[emb_pkg::CTRL_EN_BIT];
						next_s.bp_pulse = wb_req.dat[emb_pkg::CTRL_PULSE_BIT];
						clear_brk = wb_req.dat[emb_pkg::CTRL_BREAK_BIT];
					end
				end
				emb_pkg::REG_BP_ADDR:
				begin
					if (wb_req.sel[0])
					begin
						next_s.bp_addr[7:0] = wb_req.dat[7:0];
					end
					if (wb_req.sel[1])
					begin
						next_s.bp_addr[15:8] = wb_req.dat[15:8];
					end
				end
				emb_pkg::REG_IRQ_STATUS:
				begin
					if (wb_req.sel[0])
					begin
						next_s.status = next_s.status &
							~wb_req.dat[emb_pkg::IRQ_WIDTH-1:0];
					end
				end
				emb_pkg::REG_IRQ_MASK:
				begin
					if (wb_req.sel[0])
					begin
						next_s.mask = wb_req.dat[emb_pkg::IRQ_WIDTH-1:0];
					end
				end
				default:
				begin
					next_s.mask = next_s.mask;
				end
			endcase
		end

		// Writing one to the break bit clears the held breakpoint.
		if (clear_brk)
		begin
			next_s.brk = 1'b0; // [R10]
		end

		// The access-done event sets its status bit after any clear, so the set wins.
		if (s.phase == emb_pkg::PH_ACCESS && s.wait_cnt == 4'h0)
		begin
			next_s.status[emb_pkg::IRQ_DONE_BIT] = 1'b1;
		end

		// Breakpoint: a new match wins over a clear in the same cycle.
		if (bp_hit)
		begin
			next_s.status[emb_pkg::IRQ_BREAK_BIT] = 1'b1;
			if (s.bp_pulse)
			begin
				next_s.pulse_cnt = PULSE_LOAD; // [R9]
			end
			else
			begin
				next_s.brk = 1'b1; // [R10]
			end
		end
		else if (s.pulse_cnt != 4'h0)
		begin
			next_s.pulse_cnt = s.pulse_cnt - 4'h1; // [R9]
		end
		next_s.bkpt = (next_s.pulse_cnt != 4'h0) || next_s.brk; // [R8]

		// Suspend drives the data pins low; on leaving it only a write cycle keeps them driven.
		if (suspend)
		begin
			next_s.oe   = 1'b1; // [R4]
			next_s.dout = 8'h00;
		end
		else if (s.susp)
		begin
			next_s.oe = (next_s.phase == emb_pkg::PH_ACCESS) && next_s.wr; // [R1] [R2]
		end

		next_s.irq = |(next_s.status & next_s.mask);

		// Read data for the register bus, captured with ack.
		read_word = 32'h0000_0000;
		case (wb_req.adr)
			emb_pkg::REG_CTRL:
			begin
				read_word[emb_pkg::CTRL_EN_BIT]    = s.bp_en;
				read_word[emb_pkg::CTRL_PULSE_BIT] = s.bp_pulse;
				read_word[emb_pkg::CTRL_BREAK_BIT] = s.brk;
			end
			emb_pkg::REG_BP_ADDR:
			begin
				read_word[15:0] = s.bp_addr;
			end
			emb_pkg::REG_IRQ_STATUS:
			begin
				read_word[emb_pkg::IRQ_WIDTH-1:0] = s.status;
			end
			emb_pkg::REG_IRQ_MASK:
			begin
				read_word[emb_pkg::IRQ_WIDTH-1:0] = s.mask;
			end
			emb_pkg::REG_BUS_STATE:
			begin
				read_word[0] = s.code_sel;
				read_word[1] = s.phase != emb_pkg::PH_IDLE;
				read_word[2] = s.bkpt;
				read_word[3] = s.susp;
			end
			default:
			begin
				read_word = 32'h0000_0000;
			end
		endcase
		if (wb_req_on && !s.ack)
		begin
			next_s.rdat = read_word;
		end
	end

	// ****************************************************************
	// Registers and outputs
	// ****************************************************************

	// Registers the whole state on every edge.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s <= RESET_STATE; // [R12]
		end
		else
		begin
			s <= next_s;
		end
	end

	// Drives the ports from the state.
	assign wb_rsp.ack     = s.ack;
	assign wb_rsp.dat     = s.rdat;
	assign core_rsp.done  = s.phase == emb_pkg::PH_DONE;
	assign core_rsp.rdata = s.rdata;
	assign mem.addr       = s.addr; // [R11]
	assign mem.data_out   = s.dout;
	assign mem.data_oe    = s.oe;
	assign mem.strobe_n   = s.strobe_n;
	assign mem.bkpt       = s.bkpt;
	assign irq            = s.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence seq_pulse_hit;
		bp_hit && s.bp_pulse;
	endsequence
	sequence seq_code_start;
		s.phase == emb_pkg::PH_IDLE && core_req.valid && core_req.code;
	endsequence
	chk_idle_float: assert property ( // [R1]
		(s.phase != emb_pkg::PH_ACCESS && !s.susp && !$past(s.susp))
		|-> !mem.data_oe)
		else $error("Data bus driven outside a cycle.");
	chk_write_drive: assert property ( // [R2]
		(s.phase == emb_pkg::PH_ACCESS && s.wr && !s.susp) |-> mem.data_oe &&
		($past(s.phase) != emb_pkg::PH_ACCESS || $stable(mem.data_out)))
		else $error("Write cycle lost its data drive.");
	chk_internal_quiet: assert property ( // [R3]
		(s.phase == emb_pkg::PH_IDLE && core_req.valid && !ext_access
		&& !suspend && !s.susp) |=> !mem.data_oe && mem.strobe_n)
		else $error("Internal access touched the pins.");
	chk_suspend_low: assert property ( // [R4]
		$past(suspend) |-> mem.data_oe && mem.data_out == 8'h00)
		else $error("Suspend did not drive the bus low.");
	chk_strobe_code: assert property ( // [R5]
		!mem.strobe_n |-> s.phase == emb_pkg::PH_ACCESS && s.code)
		else $error("Strobe active outside a code fetch.");
	chk_low_range: assert property ( // [R6]
		(!mem.strobe_n && !$past(s.code_sel, 2))
		|-> mem.addr >= emb_pkg::EXT_CODE_BASE || $past(s.code_sel))
		else $error("Strobe below the external code range.");
	chk_full_range: assert property ( // [R7]
		(seq_code_start ##0 s.code_sel) |=> !mem.strobe_n [*2])
		else $error("Selected fetch did not strobe.");
	chk_pulse_len: assert property ( // [R9]
		seq_pulse_hit |=> mem.bkpt [*8])
		else $error("Breakpoint pulse too short.");
	chk_latch_hold: assert property ( // [R10]
		(bp_hit && !s.bp_pulse) |=> mem.bkpt && s.brk ##1 mem.bkpt)
		else $error("Latched breakpoint not held.");
	chk_addr_follow: assert property ( // [R11]
		s.phase == emb_pkg::PH_IDLE |=> mem.addr == $past(core_req.addr))
		else $error("Address pins do not follow the core.");

endmodule

`default_nettype wire

//--- emb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model #(
	parameter int LAG = 0
) (
	input  wire logic                  clock,
	input  wire emb_pkg::emb_mem_out_t mem,
	output logic [7:0]                 data_line,
	output logic [7:0]                 wr_data
);
	logic [7:0]  good;
	logic [15:0] seen = 16'h0000;
	logic [3:0]  age  = 4'h0;

	// The stored byte is a fixed mix of the two address halves.
	assign good = mem.addr[7:0] ^ mem.addr[15:8] ^ 8'h5a;

	// Count how long the address has stood, so a slow part can be modelled.
	always @(posedge clock)
	begin
		age  <= (mem.addr !== seen) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
		seen <= mem.addr;
	end

	// The device wins the wire while enabled; else the part answers, garbled until settled.
	assign data_line = mem.data_oe ? mem.data_out : ((int'(age) >= LAG) ? good : ~good);

	// Capture what the device drives onto the wire.
	always @(posedge clock)
		if (mem.data_oe)
			wr_data <= mem.data_out;
endmodule

`default_nettype wire

//--- emb_bus_test.sv
`timescale 1ns/1ps
`default_nettype none

module emb_bus_test;
	localparam int ACC = 4;
	localparam int PUL = 8;
	localparam logic [17:0] TBL [7] = '{
		{2'b10, 16'h3fff}, {2'b10, 16'h4000}, {2'b10, 16'hffff}, {2'b00, 16'h1234},
		{2'b00, 16'h8000}, {2'b01, 16'h9000}, {2'b01, 16'h0100}};

	logic                   clock;
	logic                   rst;
	emb_pkg::emb_wb_req_t   wb_req;
	emb_pkg::emb_wb_rsp_t   wb_rsp;
	emb_pkg::emb_core_req_t core_req;
	emb_pkg::emb_core_rsp_t core_rsp;
	logic                   suspend;
	logic                   sel_pin;
	logic [7:0]             data_line;
	logic [7:0]             wr_data;
	emb_pkg::emb_mem_out_t  mem;
	logic                   irq;
	logic [31:0]            q;
	int                     num_errors;
	int                     comparisons;
	int                     bk_run;
	int                     bk_len;
	int                     bk_rises;
	int                     base;

	emb_bus #(.ACCESS_CYCLES(ACC), .PULSE_CYCLES(PUL)) dut (
		.clock(clock), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.core_req(core_req), .core_rsp(core_rsp), .suspend(suspend),
		.external_code_select(sel_pin), .data_line_in(data_line), .mem(mem), .irq(irq));

	emb_mem_model #(.LAG(0)) memory (
		.clock(clock), .mem(mem), .data_line(data_line), .wr_data(wr_data));

	// Clock source.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Measure each breakpoint pulse and count its rising edges.
	always @(posedge clock)
	begin
		if (mem.bkpt === 1'b1)
		begin
			bk_run <= bk_run + 1;
			if (bk_run == 0)
				bk_rises <= bk_rises + 1;
		end
		else
		begin
			if (bk_run != 0)
				bk_len <= bk_run;
			bk_run <= 0;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic note(input string s);
		$display("test %s finished", s);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One classic bus cycle; waits for ack, then releases the request.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		wb_req <= {2'b11, w, a, 4'hf, d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_rsp.ack !== 1'b1 && n < 20);
		check(wb_rsp.ack, 1'b1);
		r = wb_rsp.dat;
		wb_req <= '0;
		repeat (2) @(negedge clock);
	endtask

	// One core access: entry holds code, write and address; pins checked mid-cycle.
	task automatic access(input logic [17:0] e);
		logic       ext;
		logic [7:0] wd;
		int         n;
		ext = e[17] ? (sel_pin || e[15:0] >= 16'h4000) : (e[15:0] > 16'h3fff);
		wd = e[7:0] ^ 8'ha5;
		n = 1;
		@(posedge clock);
		core_req <= {1'b1, e[17:16], e[15:0], wd};
		repeat (2) @(negedge clock);
		check(mem.strobe_n, !(ext && e[17]));
		check(mem.data_oe, ext && e[16]);
		check(mem.addr, e[15:0]);
		@(posedge clock);
		while (core_rsp.done !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		check(n, ext ? ACC + 1 : 1);
		if (!e[16])
			check(core_rsp.rdata, ext ? (e[7:0] ^ e[15:8] ^ 8'h5a) : 8'h00);
		core_req.valid <= 1'b0;
		@(negedge clock);
		check(mem.data_oe, 1'b0);
		if (ext && e[16])
			check(wr_data, wd);
	endtask

	// Main sequence.
	initial
	begin
		rst = 1'b1;
		wb_req = '0;
		core_req = '0;
		suspend = 1'b0;
		sel_pin = 1'b0;
		repeat (5) @(posedge clock);
		@(negedge clock);
		check(mem.addr, 16'h0000);
		check(mem.data_oe, 1'b0);
		check(mem.strobe_n, 1'b1);
		check(mem.bkpt, 1'b0);
		@(posedge clock);
		rst <= 1'b0;
		wb(1'b0, 8'h20, 32'h0, q);
		check(q, 32'h0);
		note("reset");
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clock);
			sel_pin <= s[0];
			repeat (3) @(posedge clock);
			foreach (TBL[i])
				access(TBL[i]);
		end
		note("access map");
		wb(1'b1, emb_pkg::REG_BP_ADDR, 32'h4321, q);
		wb(1'b1, emb_pkg::REG_IRQ_MASK, 32'h0, q);
		wb(1'b1, emb_pkg::REG_CTRL, 32'h3, q);
		access({2'b10, 16'h4321});
		repeat (12) @(negedge clock);
		check(bk_len, PUL);
		check(mem.bkpt, 1'b0);
		check(irq, 1'b0);
		wb(1'b1, emb_pkg::REG_IRQ_MASK, 32'h1, q);
		check(irq, 1'b1);
		wb(1'b0, emb_pkg::REG_IRQ_STATUS, 32'h0, q);
		check(q[1:0], 2'h3);
		wb(1'b1, emb_pkg::REG_IRQ_STATUS, 32'h3, q);
		check(irq, 1'b0);
		note("pulse");
		wb(1'b1, emb_pkg::REG_CTRL, 32'h1, q);
		access({2'b10, 16'h4321});
		repeat (12) @(negedge clock);
		check(mem.bkpt, 1'b1);
		wb(1'b0, emb_pkg::REG_CTRL, 32'h0, q);
		check(q[2:0], 3'h5);
		wb(1'b1, emb_pkg::REG_CTRL, 32'h5, q);
		check(mem.bkpt, 1'b0);
		wb(1'b0, emb_pkg::REG_CTRL, 32'h0, q);
		check(q[2:0], 3'h1);
		wb(1'b1, emb_pkg::REG_CTRL, 32'h0, q);
		base = bk_rises;
		access({2'b10, 16'h4321});
		repeat (12) @(negedge clock);
		check(bk_rises, base);
		note("latched");
		@(posedge clock);
		suspend <= 1'b1;
		repeat (2) @(negedge clock);
		check(mem.data_oe, 1'b1);
		check(mem.data_out, 8'h00);
		wb(1'b0, emb_pkg::REG_BUS_STATE, 32'h0, q);
		check(q[3:0], 4'h9);
		check(mem.data_oe, 1'b1);
		@(posedge clock);
		suspend <= 1'b0;
		repeat (2) @(negedge clock);
		check(mem.data_oe, 1'b0);
		note("suspend");
		final_report();
	end

	// Cut a hang short well after the tests should have ended.
	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		final_report();
	end
endmodule

`default_nettype wire
